// File: bench/scm_channel_top_bench.sv
// bench: apb register model and frames to and from a remote device
// assumes zero wait apb and bit shifts on the remote clock
`timescale 1ns/100ps
`default_nettype none
module scm_channel_top_bench;
    import scm_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, cts_n = 1'b0, dcd_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wd = 8'h00, b;
    logic [31:0] rd, prdata;
    logic        pready, pslverr, err, txd, rts_n, rx_clock_pin, rxc_oe, lclk, rxd;
    logic [9:0]  f;
    int          fails = 0, checks_done = 0;
    int          mdl [5] = '{0, 0, 0, 1, 0};
    always #5 i_clk = ~i_clk;
    scm_remote r (.i_txd(txd), .o_clk(lclk), .o_rxd(rxd));
    scm_channel_top #(.BRG_HALF(16'h0002)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata({24'h000000, wd}),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_txd(txd),
        .i_cts_n(cts_n), .i_dcd_n(dcd_n), .o_rts_n(rts_n), .i_txc(lclk), .i_rxc(lclk),
        .o_rxc(rx_clock_pin), .o_rxc_oe(rxc_oe));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (w && a <= OFS_RXCLK) mdl[a[4:2]] = d;
    endtask
    // bounded wait: a stalled transmitter must not hang the run
    task automatic grab;
        r.q.delete();
        r.run = 1'b1;
        for (int k = 0; k < 999 && r.q.size() < 10; k++) @(posedge i_clk);
        r.run = 1'b0;
        for (int k = 0; k < 10; k++) f[k] = r.q[k];
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        end_of_test;
    end
    initial begin
        void'($urandom(82));
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 8'h00);
            chk("reset reg", mdl[i], rd);
        end
        chk("rts reset", 1, rts_n);
        b[0] = rx_clock_pin;
        repeat (2) @(posedge i_clk);
        chk("rxc toggle", !b[0], rx_clock_pin);
        $display("test reset done");
        for (int i = 1; i < 5; i++) begin
            apb(1'b1, 12'(i * 4), 8'($urandom) & ~(8'(i == 3) << BREAK_BIT));
            apb(1'b0, 12'(i * 4), 8'h00);
            chk("reg", mdl[i], rd);
        end
        chk("rxc drive", mdl[4][7:5] == 3'h4, rxc_oe);
        apb(1'b0, 12'h020, 8'h00);
        chk("unmapped", 1, err);
        for (int i = 1; i < 5; i++) apb(1'b1, 12'(i * 4), 8'h00);
        repeat (4) @(posedge i_clk);
        chk("rts plain", 0, rts_n);
        $display("test registers done");
        apb(1'b1, OFS_PROTOCOL, 8'h10);
        apb(1'b1, OFS_LINE, 8'h01);
        apb(1'b1, OFS_FORMAT, 8'h16);
        b = 8'($urandom);
        apb(1'b1, OFS_TXDATA, b);
        repeat (3) @(posedge i_clk);
        chk("rts sending", 0, rts_n);
        grab;
        chk("tx frame", {1'b1, ^b[6:0], b[6:0], 1'b0}, f);
        repeat (9) @(posedge i_clk);
        chk("rts idle", 1, rts_n);
        $display("test transmit done");
        cts_n <= 1'b1;
        apb(1'b1, OFS_TXDATA, 8'h00);
        grab;
        chk("cts hold", 10'h3ff, f);
        b = 8'($urandom);
        r.send({1'b1, ^b[6:0], b[6:0], 1'b0});
        apb(1'b0, OFS_RXDATA, 8'h00);
        chk("rx char", {25'h0, b[6:0]}, rd);
        dcd_n <= 1'b1;
        r.send(10'h200);
        apb(1'b0, OFS_RXDATA, 8'h00);
        chk("rx kept", {25'h0, b[6:0]}, rd);
        $display("test modem lines done");
        apb(1'b1, OFS_LINE, 8'h21);
        grab;
        chk("break start", 10'h001, f);
        apb(1'b0, OFS_STATUS, 8'h00);
        chk("status", 32'h39, rd);
        repeat (2) grab;
        chk("break held", 10'h000, f);
        apb(1'b1, OFS_LINE, 8'h01);
        $display("test break done");
        for (int c = 1; c < 4; c += 2) begin
            apb(1'b1, OFS_CONNECT, 8'(c));
            @(posedge i_clk) r.o_rxd <= 1'b0;
            repeat (6) @(posedge i_clk);
            chk("echo low", 0, txd);
            r.o_rxd <= 1'b1;
            repeat (6) @(posedge i_clk);
            chk("echo high", 1, txd);
        end
        $display("test connection done");
        end_of_test;
    end
endmodule
`default_nettype wire

// File: bench/scm_remote.sv
// remote serial device: bit clock, receive line driver, transmit line capture
// assumes the channel shifts on clock falls and samples on rises
`timescale 1ns/100ps
`default_nettype none
module scm_remote (
    // line from the channel
    input  wire logic i_txd,
    // bit clock and line into the channel
    output logic      o_clk,
    output logic      o_rxd
);
    logic run = 1'b0;
    logic q[$];
    initial o_clk = 1'b1;
    initial o_rxd = 1'b1;
    // clock stands still high between frames
    always #80 o_clk = run ? ~o_clk : 1'b1;
    // channel sees the fall late, so the old bit still stands here
    always @(negedge o_clk) q.push_back(i_txd);
    task automatic send(input logic [9:0] f);
        run = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(negedge o_clk) o_rxd = f[i];
        end
        repeat (3) @(negedge o_clk);
        o_rxd = 1'b1;
        run = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: logic/scm_channel_top.sv
// serial channel: mode registers over apb, transmitter, receiver, modem lines
// assumes apb on i_clk; all line pins and external clocks are asynchronous
//
// Decided for this implementation: the APB slave port and the address map.

`timescale 1ns/100ps
`default_nettype none

module scm_channel_top
    import scm_pkg::*;
#(
    parameter logic [15:0] BRG_HALF = BRG_HALF_DEFAULT
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // serial line and modem pins
    input  wire logic        i_rxd,
    output logic             o_txd,
    input  wire logic        i_cts_n,
    input  wire logic        i_dcd_n,
    output logic             o_rts_n,
    // bit clock pins
    input  wire logic        i_txc,
    input  wire logic        i_rxc,
    output logic             o_rxc,
    output logic             o_rxc_oe
);

    typedef struct packed {
        logic [7:0]       proto_cfg;
        logic [7:0]       format_cfg;
        logic [7:0]       connect_cfg;
        logic [7:0]       line_ctl;
        logic [7:0]       rxclk_cfg;
        logic [7:0]       txbuf;
        logic             txfull;
        logic [7:0]       rxbuf;
        logic             rxfull;
        logic [31:0]      prdata;
        logic             pslverr;
        logic [15:0]      brg_cnt;
        logic             brg_clk;
        logic             txclk_prev;
        logic             rxclk_prev;
        scm_tx_state_type tx_state;
        logic [6:0]       tx_pre;
        logic [7:0]       tx_sh;
        logic [3:0]       tx_bits;
        logic [3:0]       tx_last;
        logic             tx_par_on;
        logic             tx_par;
        logic             break_on;
        logic             tx_line;
        logic             txd;
        logic             rts_n;
        scm_rx_state_type rx_state;
        logic [6:0]       rx_pre;
        logic [7:0]       rx_sh;
        logic [3:0]       rx_bits;
        logic [3:0]       rx_last;
        logic             rx_par_on;
    } scm_state_type;

    scm_state_type st_ff;
    scm_state_type nxt_st;

    logic [4:0] pins_s;
    logic       rxd_s;
    logic       cts_s;
    logic       dcd_s;
    logic       txc_s;
    logic       rxc_s;

    scm_sync #(
        .WIDTH (5)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_rxc, i_txc, i_dcd_n, i_cts_n, i_rxd}),
        .o_sync  (pins_s)
    );

    assign rxd_s = pins_s[0];
    assign cts_s = pins_s[1];
    assign dcd_s = pins_s[2];
    assign txc_s = pins_s[3];
    assign rxc_s = pins_s[4];

    function automatic logic [6:0] rate_div(input logic [1:0] code);
        case (code)
            2'h0:    rate_div = 7'h01;
            2'h1:    rate_div = 7'h10;
            2'h2:    rate_div = 7'h20;
            default: rate_div = 7'h40;
        endcase
    endfunction

    // decoded configuration
    logic       sync_mode;
    logic       auto_en;
    logic       echo_mode;
    logic       loop_mode;
    logic       clk_master;
    logic [6:0] div;
    logic       cts_block;
    logic       dcd_block;
    logic       tx_src;
    logic       rx_src;
    logic       tx_fall;
    logic       rx_rise;
    logic       rx_in;

    assign sync_mode  = st_ff.proto_cfg[PROTO_HI:PROTO_LO] == PROTO_SYNC; // RQ1
    assign auto_en    = st_ff.proto_cfg[AUTO_BIT];
    assign echo_mode  = st_ff.connect_cfg[1:0] == CONN_ECHO; // RQ13
    assign loop_mode  = st_ff.connect_cfg[1:0] == CONN_LOOP; // RQ13
    assign clk_master = st_ff.rxclk_cfg[RXCS_HI:RXCS_LO] == RXCS_MASTER;
    assign div        = rate_div(st_ff.format_cfg[RATE_HI -: 2]); // RQ9
    assign cts_block  = auto_en && cts_s; // RQ4
    assign dcd_block  = auto_en && dcd_s; // RQ5
    assign tx_src     = clk_master ? st_ff.brg_clk : txc_s; // RQ20
    assign rx_src     = clk_master ? st_ff.brg_clk : rxc_s; // RQ19
    assign tx_fall    = st_ff.txclk_prev && !tx_src;
    assign rx_rise    = !st_ff.rxclk_prev && rx_src;
    assign rx_in      = loop_mode ? st_ff.tx_line : rxd_s; // RQ15

    always_comb begin
        logic       rx_store;
        logic       tx_tick;
        logic       rx_tick;
        logic [1:0] par_sel;
        logic [7:0] ld_data;
        rx_store = 1'b0;
        tx_tick  = 1'b0;
        rx_tick  = 1'b0;
        par_sel  = st_ff.format_cfg[1:0];
        ld_data  = st_ff.txbuf;
        nxt_st   = st_ff;

        // baud generator: free-running square wave
        if (st_ff.brg_cnt >= BRG_HALF - 16'h0001) begin
            nxt_st.brg_cnt = '0;
            nxt_st.brg_clk = !st_ff.brg_clk;
        end else begin
            nxt_st.brg_cnt = st_ff.brg_cnt + 16'h0001;
        end
        nxt_st.txclk_prev = tx_src;
        nxt_st.rxclk_prev = rx_src;

        // transmitter, shifting on the falling bit clock edge
        if (tx_fall && st_ff.tx_state != TX_IDLE) begin
            if (st_ff.tx_pre >= div - 7'h01) begin // RQ9
                nxt_st.tx_pre = '0;
                tx_tick = 1'b1;
            end else begin
                nxt_st.tx_pre = st_ff.tx_pre + 7'h01;
            end
        end
        if (!st_ff.line_ctl[BREAK_BIT]) begin
            nxt_st.break_on = 1'b0;
        end
        if (tx_fall && st_ff.line_ctl[BREAK_BIT] && !sync_mode) begin
            nxt_st.break_on = 1'b1; // RQ16
            nxt_st.tx_state = TX_IDLE; // RQ16
            nxt_st.tx_sh    = '0;
        end else begin
            case (st_ff.tx_state)
                TX_IDLE: begin
                    // echo disables the transmitter; cts holds the buffer back
                    if (st_ff.txfull && !cts_block && !echo_mode && !st_ff.break_on) begin // RQ4 RQ14
                        nxt_st.txfull    = 1'b0;
                        nxt_st.tx_pre    = '0;
                        nxt_st.tx_bits   = '0;
                        nxt_st.tx_last   = (st_ff.format_cfg[TXLEN_HI -: 2] == LEN_SEVEN) ?
                                           LAST_BIT_7 : LAST_BIT_8; // RQ10
                        if (st_ff.format_cfg[TXLEN_HI -: 2] == LEN_SEVEN) begin
                            ld_data[7] = 1'b0;
                        end
                        nxt_st.tx_sh     = ld_data;
                        nxt_st.tx_par_on = !sync_mode && par_sel != PAR_NONE; // RQ12
                        nxt_st.tx_par    = (par_sel == PAR_MP) ? st_ff.line_ctl[MP_BIT] :
                                           ((^ld_data) ^ (par_sel == PAR_ODD)); // RQ12
                        nxt_st.line_ctl[MP_BIT] = 1'b0;
                        nxt_st.tx_state  = sync_mode ? TX_DATA : TX_START; // RQ1
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        nxt_st.tx_state = TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick) begin
                        nxt_st.tx_sh   = {1'b0, st_ff.tx_sh[7:1]};
                        nxt_st.tx_bits = st_ff.tx_bits + 4'h1;
                        if (st_ff.tx_bits == st_ff.tx_last) begin
                            nxt_st.tx_bits  = '0;
                            nxt_st.tx_state = sync_mode ? TX_IDLE :
                                              (st_ff.tx_par_on ? TX_PAR : TX_STOP);
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_tick) begin
                        nxt_st.tx_state = TX_STOP;
                    end
                end
                default: begin
                    // stop length read live so a change hits the current character
                    if (tx_tick) begin
                        nxt_st.tx_bits = st_ff.tx_bits + 4'h1;
                        if (st_ff.proto_cfg[1:0] != STOP_TWO || st_ff.tx_bits != '0) begin // RQ8
                            nxt_st.tx_state = TX_IDLE;
                        end
                    end
                end
            endcase
        end

        case (nxt_st.tx_state)
            TX_START: nxt_st.tx_line = 1'b0;
            TX_DATA:  nxt_st.tx_line = nxt_st.tx_sh[0];
            TX_PAR:   nxt_st.tx_line = nxt_st.tx_par;
            default:  nxt_st.tx_line = !nxt_st.break_on; // RQ16
        endcase
        nxt_st.txd = (echo_mode || loop_mode) ? rxd_s : nxt_st.tx_line; // RQ14 RQ15
        nxt_st.rts_n = (auto_en && nxt_st.tx_state != TX_IDLE) ? 1'b0 :
                       st_ff.line_ctl[RTS_BIT]; // RQ3 RQ6 RQ7

        // receiver, sampling on the rising bit clock edge
        if (rx_rise && st_ff.rx_state != RX_IDLE) begin
            nxt_st.rx_pre = st_ff.rx_pre + 7'h01;
            if (st_ff.rx_state == RX_START) begin
                rx_tick = st_ff.rx_pre >= (div >> 1) - 7'h01; // RQ9
            end else begin
                rx_tick = st_ff.rx_pre >= div - 7'h01; // RQ9
            end
            if (rx_tick) begin
                nxt_st.rx_pre = '0;
            end
        end
        case (st_ff.rx_state)
            RX_IDLE: begin
                if (rx_rise && (sync_mode || !rx_in)) begin
                    nxt_st.rx_pre    = '0;
                    nxt_st.rx_bits   = '0;
                    nxt_st.rx_last   = (st_ff.format_cfg[RXLEN_HI -: 2] == LEN_SEVEN) ?
                                       LAST_BIT_7 : LAST_BIT_8; // RQ11
                    nxt_st.rx_par_on = !sync_mode && par_sel != PAR_NONE; // RQ12
                    // at rate one the detecting edge is the whole start bit
                    nxt_st.rx_state  = (sync_mode || div == 7'h01) ? RX_DATA : RX_START;
                end
            end
            RX_START: begin
                if (rx_tick) begin
                    nxt_st.rx_state = rx_in ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    nxt_st.rx_sh   = {rx_in, st_ff.rx_sh[7:1]};
                    nxt_st.rx_bits = st_ff.rx_bits + 4'h1;
                    if (st_ff.rx_bits == st_ff.rx_last) begin
                        nxt_st.rx_state = sync_mode ? RX_IDLE :
                                          (st_ff.rx_par_on ? RX_PAR : RX_STOP);
                        rx_store = sync_mode;
                    end
                end
            end
            RX_PAR: begin
                if (rx_tick) begin
                    nxt_st.rx_state = RX_STOP;
                end
            end
            default: begin
                if (rx_tick) begin
                    nxt_st.rx_state = RX_IDLE;
                    rx_store = 1'b1;
                end
            end
        endcase
        if (dcd_block) begin
            nxt_st.rx_state = RX_IDLE; // RQ5
            rx_store = 1'b0; // RQ5
        end

        // apb: read data captured in the setup phase, writes at the access edge
        if (i_psel && !i_penable) begin
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata  = '0;
            if (i_paddr == OFS_PROTOCOL) begin
                nxt_st.prdata[7:0] = st_ff.proto_cfg;
            end else if (i_paddr == OFS_FORMAT) begin
                nxt_st.prdata[7:0] = st_ff.format_cfg;
            end else if (i_paddr == OFS_CONNECT) begin
                nxt_st.prdata[7:0] = st_ff.connect_cfg;
            end else if (i_paddr == OFS_LINE) begin
                nxt_st.prdata[7:0] = st_ff.line_ctl;
            end else if (i_paddr == OFS_RXCLK) begin
                nxt_st.prdata[7:0] = st_ff.rxclk_cfg;
            end else if (i_paddr == OFS_TXDATA) begin
                nxt_st.prdata[7:0] = st_ff.txbuf;
            end else if (i_paddr == OFS_RXDATA) begin
                nxt_st.prdata[7:0] = st_ff.rxbuf;
            end else if (i_paddr == OFS_STATUS) begin
                nxt_st.prdata[ST_TXFULL] = st_ff.txfull;
                nxt_st.prdata[ST_RXFULL] = st_ff.rxfull;
                nxt_st.prdata[ST_TXBUSY] = st_ff.tx_state != TX_IDLE;
                nxt_st.prdata[ST_CTS]    = cts_s; // RQ3
                nxt_st.prdata[ST_DCD]    = dcd_s; // RQ3
                nxt_st.prdata[ST_BREAK]  = st_ff.break_on;
            end else begin
                nxt_st.pslverr = 1'b1;
            end
        end
        if (i_psel && i_penable && !st_ff.pslverr) begin
            if (!i_pwrite && i_paddr == OFS_RXDATA) begin
                nxt_st.rxfull = 1'b0;
            end else if (i_pwrite && i_paddr == OFS_PROTOCOL) begin
                nxt_st.proto_cfg = i_pwdata[7:0];
            end else if (i_pwrite && i_paddr == OFS_FORMAT) begin
                nxt_st.format_cfg = i_pwdata[7:0];
            end else if (i_pwrite && i_paddr == OFS_CONNECT) begin
                nxt_st.connect_cfg = i_pwdata[7:0];
            end else if (i_pwrite && i_paddr == OFS_LINE) begin
                nxt_st.line_ctl = i_pwdata[7:0];
            end else if (i_pwrite && i_paddr == OFS_RXCLK) begin
                nxt_st.rxclk_cfg = i_pwdata[7:0]; // RQ22
            end else if (i_pwrite && i_paddr == OFS_TXDATA) begin
                nxt_st.txbuf  = i_pwdata[7:0];
                nxt_st.txfull = 1'b1;
            end
        end
        // a character landing in the clearing cycle still sets the flag
        if (rx_store) begin
            nxt_st.rxbuf  = (st_ff.rx_last == LAST_BIT_7) ? {1'b0, nxt_st.rx_sh[7:1]} :
                            nxt_st.rx_sh; // RQ11
            nxt_st.rxfull = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_ff            <= '0;
            st_ff.line_ctl   <= RST_LINE;
            st_ff.proto_cfg  <= RST_CONFIG;
            st_ff.tx_state   <= TX_IDLE;
            st_ff.rx_state   <= RX_IDLE;
            st_ff.tx_line    <= 1'b1;
            st_ff.txd        <= 1'b1;
            st_ff.rts_n      <= 1'b1;
            st_ff.txclk_prev <= 1'b1;
            st_ff.rxclk_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_prdata  = st_ff.prdata;
    assign o_pready  = 1'b1;
    assign o_pslverr = st_ff.pslverr && i_psel && i_penable;
    assign o_txd     = st_ff.txd;
    assign o_rts_n   = st_ff.rts_n;
    assign o_rxc     = st_ff.brg_clk;
    assign o_rxc_oe  = clk_master; // RQ19 RQ20

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    rts_auto_a: assert property (auto_en && $stable(auto_en) && st_ff.tx_state != TX_IDLE // RQ6
        |-> !o_rts_n)
        else $error("rts not low while sending");
    rts_plain_a: assert property (!auto_en |=> o_rts_n == $past(st_ff.line_ctl[RTS_BIT])) // RQ7
        else $error("rts does not follow control bit");
    cts_hold_a: assert property (cts_block && st_ff.tx_state == TX_IDLE && !st_ff.break_on
        |=> st_ff.tx_state == TX_IDLE) // RQ4
        else $error("character loaded while cts high");
    dcd_drop_a: assert property (dcd_block |=> st_ff.rx_state == RX_IDLE && $stable(st_ff.rxbuf)) // RQ5
        else $error("reception not stopped by dcd");
    echo_pin_a: assert property (echo_mode && $stable(echo_mode) |=> o_txd == $past(rxd_s)) // RQ14
        else $error("echo path broken");
    echo_mute_a: assert property (echo_mode && st_ff.tx_state == TX_IDLE
        |=> st_ff.tx_state == TX_IDLE) // RQ14
        else $error("transmitter ran in echo mode");
    break_low_a: assert property (st_ff.break_on |-> st_ff.tx_state == TX_IDLE && !st_ff.tx_line) // RQ16
        else $error("break not a cleared space");
    break_start_a: assert property (tx_fall && st_ff.line_ctl[BREAK_BIT] && !sync_mode
        |=> st_ff.break_on && ($past(echo_mode || loop_mode) || !o_txd)) // RQ16
        else $error("break not started at clock fall");
    // generator must toggle within one half period while it is driven out
    localparam int BRG_SPAN = BRG_HALF;
    rxc_drive_a: assert property (clk_master |-> o_rxc_oe ##[1:BRG_SPAN] $changed(o_rxc)) // RQ19
        else $error("baud output not driven");
    loop_feed_a: assert property (loop_mode && $stable(loop_mode) |-> rx_in == st_ff.tx_line // RQ15
        ##1 o_txd == $past(rxd_s))
        else $error("loopback not fed from transmitter");

    break_seen_c: cover property (st_ff.break_on ##1 !st_ff.break_on);
    rx_char_c: cover property ($rose(st_ff.rxfull));
    loop_char_c: cover property (loop_mode && $rose(st_ff.rxfull));
    cts_wait_c: cover property (cts_block && st_ff.txfull ##[1:50] !cts_block);

endmodule

`default_nettype wire

// File: logic/scm_pkg.sv
// constants, field layout and state types of the serial channel mode control block
// assumes an apb master on the system clock and a remote serial device on the pins
//
// Summary of operation
// RQ1: protocol code 000 is asynchronous, 110 clock-synchronous; others reserved, treated as async.
// RQ2: software changes the protocol only just after reset or channel reset.
// RQ3: auto-enable clear: cts and dcd are plain inputs, rts a plain output.
// RQ4: auto-enable set and cts high: no new character leaves the buffer.
// RQ5: auto-enable set and dcd high: reception stops, partial character lost, buffer kept.
// RQ6: auto-enable set: rts low while a character is sent, else the control bit.
// RQ7: control bit 0 drives rts low, 1 drives it high.
// RQ8: async stop length one (00) or two (10); applies to the current character.
// RQ9: async rate divides the bit clock by 1, 16, 32, 64; sync needs 00.
// RQ10: transmit length eight (00) or seven (01) bits, latched per character.
// RQ11: receive length eight (00) or seven (01) bits, latched per character.
// RQ12: parity none, multiprocessor bit, even or odd; latched per character.
// RQ13: connection full duplex 00, auto-echo 01, local loopback 11; 10 reserved.
// RQ14: auto-echo: receive pin goes straight to transmit pin; own transmission off.
// RQ15: loopback: transmit line feeds the receiver; receive pin goes to transmit pin.
// RQ16: async break sends space from the next transmit clock fall, clears the shifter.
// RQ17: software holds break for at least two character periods.
// RQ18: software keeps break at 0 in synchronous mode.
// RQ19: async receive clock 000 from its pin, 100 from the baud generator, driven out.
// RQ20: sync receive clock select 000 slave, 100 master; transmitter also master.
// RQ21: software writes receive clock select only while the channel is idle.
// RQ22: low four receive clock bits mirror the baud divide; software reset keeps registers. The code stores all eight written bits and has no software reset.

package scm_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_PROTOCOL = 12'h000;
    localparam logic [11:0] OFS_FORMAT   = 12'h004;
    localparam logic [11:0] OFS_CONNECT  = 12'h008;
    localparam logic [11:0] OFS_LINE     = 12'h00c;
    localparam logic [11:0] OFS_RXCLK    = 12'h010;
    localparam logic [11:0] OFS_TXDATA   = 12'h014;
    localparam logic [11:0] OFS_RXDATA   = 12'h018;
    localparam logic [11:0] OFS_STATUS   = 12'h01c;

    // reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_LINE   = 8'h01;

    // protocol_mode_config fields
    localparam int PROTO_HI = 7;
    localparam int PROTO_LO = 5;
    localparam int AUTO_BIT = 4;
    localparam logic [2:0] PROTO_ASYNC = 3'h0;
    localparam logic [2:0] PROTO_SYNC  = 3'h6;
    localparam logic [1:0] STOP_TWO    = 2'h2;

    // character_format_config fields
    localparam int RATE_HI = 7;
    localparam int TXLEN_HI = 5;
    localparam int RXLEN_HI = 3;
    localparam logic [1:0] LEN_SEVEN  = 2'h1;
    localparam logic [1:0] PAR_NONE   = 2'h0;
    localparam logic [1:0] PAR_MP     = 2'h1;
    localparam logic [1:0] PAR_ODD    = 2'h3;

    // channel_connection_config codes
    localparam logic [1:0] CONN_ECHO = 2'h1;
    localparam logic [1:0] CONN_LOOP = 2'h3;

    // line_control bits
    localparam int RTS_BIT   = 0;
    localparam int MP_BIT    = 4;
    localparam int BREAK_BIT = 5;

    // receive_clock_select fields
    localparam int RXCS_HI = 7;
    localparam int RXCS_LO = 5;
    localparam logic [2:0] RXCS_MASTER = 3'h4;

    // status bits
    localparam int ST_TXFULL = 0;
    localparam int ST_RXFULL = 1;
    localparam int ST_TXBUSY = 2;
    localparam int ST_CTS    = 3;
    localparam int ST_DCD    = 4;
    localparam int ST_BREAK  = 5;

    // bit counts and baud generator
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_7 = 4'h6;
    localparam logic [15:0] BRG_HALF_DEFAULT = 16'h0008;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scm_tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} scm_rx_state_type;

endpackage

// File: logic/scm_sync.sv
// two-flop synchroniser bank for the line pins
// assumes pins are asynchronous to i_clk; outputs are used only on i_clk

`timescale 1ns/100ps
`default_nettype none

module scm_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } scm_sync_state_type;

    scm_sync_state_type st_ff;
    scm_sync_state_type nxt_st;

    // first stage is read by the second stage only
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = i_async;
        nxt_st.sync = st_ff.meta;
    end

    // idle line levels are high, so reset to ones avoids a false start bit
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.sync;

endmodule

`default_nettype wire
